// file: include/alj_pkg.sv
package alj_pkg;
  localparam int W = 30;
  localparam int AW = 15;
  localparam int NCH = 16;
  localparam int CW = 4;
  // register port offsets
  localparam logic [1:0] REG_ACC = 2'h0;
  localparam logic [1:0] REG_QUO = 2'h1;
  localparam logic [1:0] REG_STAT = 2'h2;
  localparam logic [1:0] REG_SW = 2'h3;
  // status fields
  localparam int STAT_HALT = 0;
  localparam int STAT_INTEN = 1;
  localparam logic [W-1:0] ACC_RST = 30'h00000000;
  localparam logic [W-1:0] ONE = 30'h00000001;
  localparam logic [W-1:0] MSB = 30'h20000000;

  // opcodes, octal 32 .. 62
  typedef enum logic [5:0] {
    OP_STSUM = 6'h1A, OP_STDIF = 6'h1B, OP_RPQADD = 6'h1C, OP_RPQSUB = 6'h1D,
    OP_RPINC = 6'h1E, OP_RPDEC = 6'h1F, OP_LPENT = 6'h20, OP_LPADD = 6'h21,
    OP_LPSUB = 6'h22, OP_MCMP = 6'h23, OP_LPREP = 6'h24, OP_RLPADD = 6'h25,
    OP_RLPSUB = 6'h26, OP_LPST = 6'h27, OP_SSET = 6'h28, OP_SCPL = 6'h29,
    OP_SCLR = 6'h2A, OP_SSUB = 6'h2B, OP_RSSET = 6'h2C, OP_RSCPL = 6'h2D,
    OP_RSCLR = 6'h2E, OP_RSSUB = 6'h2F, OP_JARI = 6'h30, OP_JMAN = 6'h31,
    OP_JINB = 6'h32
  } alj_op_t;

  typedef struct packed {
    alj_op_t op;
    logic [2:0] j;
    logic [2:0] k;
    logic [CW-1:0] chan;
    logic [AW-1:0] addr;
    logic [W-1:0] y;
  } alj_cmd_t;

  typedef struct packed {
    logic valid;
    logic kdir;
    logic [2:0] k;
    logic [AW-1:0] addr;
    logic [W-1:0] data;
  } alj_store_t;

  typedef struct packed {
    logic done;
    logic skip;
    logic jump;
    logic [AW-1:0] target;
    logic lock_clr;
  } alj_flow_t;
endpackage

// file: rtl/alj_exec.sv
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Operation
// - accumulator and quotient each thirty bits wide
// - store sum: A plus Q, stored too
// - store difference: A minus Q, stored too
// - replace: Q plus operand into A, memory
// - replace: complemented Q minus operand, both places
// - replace increment: one plus operand, both places
// - replace decrement: complemented one minus operand
// - logical product into A, parity skips
// - operand and Q into A, stored, parity
// - add operand-and-Q product to A
// - subtract operand-and-Q product from A
// - masked compare skips, leaves registers unchanged
// - replace add/subtract product, stored both places
// - store A-and-Q product, registers unchanged
// - selective set, complement, clear on operand ones
// - selective substitute under Q mask
// - replace selective forms store resulting A
// - replace substitute clears, sets product, stores
// - satisfied jump loads operand address as next
// - arithmetic jump 0/1 enable interrupts, clear lockout
// - arithmetic jump on Q and A conditions
// - manual jump on console jump switches
// - manual jump with halt on stop switches
// - jump when selected input buffer active
module alj_exec (
  input wire logic clock,
  input wire logic rst,
  input wire logic exec_valid,
  input wire alj_pkg::alj_cmd_t exec_cmd,
  output logic exec_ready,
  output alj_pkg::alj_store_t store,
  output alj_pkg::alj_flow_t flow,
  output logic halted,
  output logic int_enable,
  input wire logic [3:1] jump_sw,
  input wire logic [7:5] stop_sw,
  input wire logic [alj_pkg::NCH-1:0] inbuf_active,
  input wire logic [1:0] reg_addr,
  input wire logic [alj_pkg::W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [alj_pkg::W-1:0] reg_rdata
);

  typedef struct packed {
    logic [alj_pkg::W-1:0] acc;
    logic [alj_pkg::W-1:0] quo;
    logic halt;
    logic int_en;
    alj_pkg::alj_store_t st;
    alj_pkg::alj_flow_t fl;
    logic [alj_pkg::W-1:0] rdata;
    logic [5:0] sw_m;
    logic [5:0] sw_s;
    logic [alj_pkg::NCH-1:0] ib_m;
    logic [alj_pkg::NCH-1:0] ib_s;
  } alj_state_t;

  alj_state_t s_q;
  alj_state_t s_d;

  //////////////////////////////////////////////////////////////////////////////
  // ones complement helpers

  // end-around carry; two carries cannot occur
  function automatic logic [alj_pkg::W-1:0] oc_add(input logic [alj_pkg::W-1:0] a,
                                                   input logic [alj_pkg::W-1:0] b);
    logic [alj_pkg::W:0] s;
    s = {1'b0, a} + {1'b0, b};
    oc_add = s[alj_pkg::W-1:0] + {{(alj_pkg::W-1){1'b0}}, s[alj_pkg::W]};
  endfunction

  function automatic logic [alj_pkg::W-1:0] oc_sub(input logic [alj_pkg::W-1:0] a,
                                                   input logic [alj_pkg::W-1:0] b);
    oc_sub = oc_add(a, ~b);
  endfunction

  // common branch condition table, used by skips and the arithmetic jump
  function automatic logic cond(input logic [2:0] j,
                                input logic [alj_pkg::W-1:0] a,
                                input logic [alj_pkg::W-1:0] q);
    case (j)
      3'h0: cond = 1'b0;
      3'h1: cond = 1'b1;
      3'h2: cond = ~q[alj_pkg::W-1];
      3'h3: cond = q[alj_pkg::W-1];
      3'h4: cond = (a == alj_pkg::ACC_RST);
      3'h5: cond = (a != alj_pkg::ACC_RST);
      3'h6: cond = ~a[alj_pkg::W-1];
      default: cond = a[alj_pkg::W-1];
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // next state

  logic [alj_pkg::W-1:0] y;
  logic [alj_pkg::W-1:0] a;
  logic [alj_pkg::W-1:0] q;
  logic [alj_pkg::W-1:0] lp;
  logic [alj_pkg::W-1:0] res;
  logic go;
  logic wr_a;
  logic do_st;
  logic kdir;
  logic skip;
  logic jmp;
  logic stop;
  logic [2:0] sj;
  logic [2:0] xj;

  assign exec_ready = ~s_q.halt;
  assign go = exec_valid & ~s_q.halt;

  always_comb begin
    s_d = s_q;
    y = exec_cmd.y;
    a = s_q.acc;
    q = s_q.quo;
    lp = y & q;
    res = a;
    wr_a = 1'b0;
    do_st = 1'b0;
    kdir = 1'b0;
    skip = 1'b0;
    jmp = 1'b0;
    stop = 1'b0;
    sj = s_q.sw_s[2:0];
    xj = s_q.sw_s[5:3];
    s_d.fl.lock_clr = 1'b0;
    // second stage reads only the first
    s_d.sw_m = {stop_sw, jump_sw};
    s_d.sw_s = s_q.sw_m;
    s_d.ib_m = inbuf_active;
    s_d.ib_s = s_q.ib_m;
    case (exec_cmd.op)
      alj_pkg::OP_STSUM: begin
        res = oc_add(a, q);
        wr_a = 1'b1;
        do_st = 1'b1;
        kdir = 1'b1;
      end
      alj_pkg::OP_STDIF: begin
        res = oc_sub(a, q);
        wr_a = 1'b1;
        do_st = 1'b1;
        kdir = 1'b1;
      end
      alj_pkg::OP_RPQADD: begin
        res = oc_add(q, y);
        wr_a = 1'b1;
        do_st = 1'b1;
      end
      alj_pkg::OP_RPQSUB: begin
        res = ~oc_sub(q, y);
        wr_a = 1'b1;
        do_st = 1'b1;
      end
      alj_pkg::OP_RPINC: begin
        res = oc_add(alj_pkg::ONE, y);
        wr_a = 1'b1;
        do_st = 1'b1;
      end
      alj_pkg::OP_RPDEC: begin
        res = ~oc_sub(alj_pkg::ONE, y);
        wr_a = 1'b1;
        do_st = 1'b1;
      end
      alj_pkg::OP_LPENT: begin
        res = y & a;
        wr_a = 1'b1;
      end
      alj_pkg::OP_LPADD: begin
        res = oc_add(a, lp);
        wr_a = 1'b1;
      end
      alj_pkg::OP_LPSUB: begin
        res = oc_sub(a, lp);
        wr_a = 1'b1;
      end
      alj_pkg::OP_MCMP: begin
        // skip judged on the difference; A is not written, so it keeps its value
        skip = cond(exec_cmd.j, oc_sub(a, lp), q);
      end
      alj_pkg::OP_LPREP: begin
        res = lp;
        wr_a = 1'b1;
        do_st = 1'b1;
      end
      alj_pkg::OP_RLPADD: begin
        res = oc_add(a, lp);
        wr_a = 1'b1;
        do_st = 1'b1;
      end
      alj_pkg::OP_RLPSUB: begin
        res = oc_sub(a, lp);
        wr_a = 1'b1;
        do_st = 1'b1;
      end
      alj_pkg::OP_LPST: begin
        res = a & q;
        do_st = 1'b1;
        kdir = 1'b1;
      end
      alj_pkg::OP_SSET, alj_pkg::OP_RSSET: begin
        res = a | y;
        wr_a = 1'b1;
        do_st = exec_cmd.op[2];
      end
      alj_pkg::OP_SCPL, alj_pkg::OP_RSCPL: begin
        res = a ^ y;
        wr_a = 1'b1;
        do_st = exec_cmd.op[2];
      end
      alj_pkg::OP_SCLR, alj_pkg::OP_RSCLR: begin
        res = a & ~y;
        wr_a = 1'b1;
        do_st = exec_cmd.op[2];
      end
      alj_pkg::OP_SSUB, alj_pkg::OP_RSSUB: begin
        res = (a & ~q) | lp;
        wr_a = 1'b1;
        do_st = exec_cmd.op[2];
      end
      alj_pkg::OP_JARI: begin
        jmp = cond(exec_cmd.j, a, q);
        if (exec_cmd.j == 3'h0 || exec_cmd.j == 3'h1) begin
          s_d.int_en = s_q.int_en | go;
          s_d.fl.lock_clr = go;
        end
      end
      alj_pkg::OP_JMAN: begin
        if (exec_cmd.j[2]) begin
          jmp = 1'b1;
          if (exec_cmd.j == 3'h4) begin
            stop = 1'b1;
          end else begin
            stop = xj[exec_cmd.j[1:0] - 2'h1];
          end
        end else if (exec_cmd.j == 3'h0) begin
          jmp = 1'b1;
        end else begin
          jmp = sj[exec_cmd.j[1:0] - 2'h1];
        end
      end
      alj_pkg::OP_JINB: begin
        jmp = s_q.ib_s[exec_cmd.chan];
      end
      default: begin
        res = a;
      end
    endcase
    // parity skips replace the common table for j of 2 and 3
    if (wr_a && exec_cmd.op != alj_pkg::OP_MCMP) begin
      if ((exec_cmd.op == alj_pkg::OP_LPENT || exec_cmd.op == alj_pkg::OP_LPREP)
          && exec_cmd.j[2:1] == 2'h1) begin
        skip = exec_cmd.j[0] ? ^res : ~^res;
      end else begin
        skip = cond(exec_cmd.j, res, q);
      end
    end
    s_d.st.valid = go & do_st;
    s_d.st.kdir = kdir;
    s_d.st.k = exec_cmd.k;
    s_d.st.addr = exec_cmd.addr;
    s_d.st.data = res;
    s_d.fl.done = go;
    s_d.fl.skip = go & skip;
    s_d.fl.jump = go & jmp;
    s_d.fl.target = exec_cmd.addr;
    // register port writes lose to the block's own updates
    if (reg_wr) begin
      if (reg_addr == alj_pkg::REG_ACC) begin
        s_d.acc = reg_wdata;
      end else if (reg_addr == alj_pkg::REG_QUO) begin
        s_d.quo = reg_wdata;
      end else if (reg_addr == alj_pkg::REG_STAT) begin
        if (reg_wdata[alj_pkg::STAT_HALT]) begin
          s_d.halt = 1'b0;
        end
        if (reg_wdata[alj_pkg::STAT_INTEN] && !s_d.fl.lock_clr) begin
          s_d.int_en = 1'b0;
        end
      end
    end
    if (go && wr_a) begin
      s_d.acc = res;
    end
    if (go && stop) begin
      s_d.halt = 1'b1;
    end
    if (reg_rd) begin
      if (reg_addr == alj_pkg::REG_ACC) begin
        s_d.rdata = s_q.acc;
      end else if (reg_addr == alj_pkg::REG_QUO) begin
        s_d.rdata = s_q.quo;
      end else if (reg_addr == alj_pkg::REG_STAT) begin
        s_d.rdata = {28'h0000000, s_q.int_en, s_q.halt};
      end else begin
        s_d.rdata = {24'h000000, s_q.sw_s};
      end
    end else begin
      s_d.rdata = alj_pkg::ACC_RST;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign store = s_q.st;
  assign flow = s_q.fl;
  assign halted = s_q.halt;
  assign int_enable = s_q.int_en;
  assign reg_rdata = s_q.rdata;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_exec(alj_pkg::alj_op_t o);
    go && !reg_wr && exec_cmd.op == o;
  endsequence

  property p_stsum;
    s_exec(alj_pkg::OP_STSUM) |=> store.valid && store.kdir
      && s_q.acc == oc_add($past(s_q.acc), $past(s_q.quo)) && store.data == s_q.acc;
  endproperty
  a_stsum: assert property (p_stsum) else $error("store sum wrong");

  property p_stdif;
    s_exec(alj_pkg::OP_STDIF) |=> s_q.acc == oc_sub($past(s_q.acc), $past(s_q.quo));
  endproperty
  a_stdif: assert property (p_stdif) else $error("store difference wrong");

  property p_rpdec;
    s_exec(alj_pkg::OP_RPDEC) |=> store.valid
      && store.data == ~oc_sub(alj_pkg::ONE, $past(exec_cmd.y));
  endproperty
  a_rpdec: assert property (p_rpdec) else $error("replace decrement wrong");

  property p_mcmp;
    s_exec(alj_pkg::OP_MCMP) |=> $stable(s_q.acc) && !store.valid;
  endproperty
  a_mcmp: assert property (p_mcmp) else $error("compare changed A");

  property p_lpst;
    s_exec(alj_pkg::OP_LPST) |=> store.data == ($past(s_q.acc) & $past(s_q.quo))
      && $stable(s_q.acc);
  endproperty
  a_lpst: assert property (p_lpst) else $error("store product wrong");

  property p_parity;
    s_exec(alj_pkg::OP_LPENT) ##0 exec_cmd.j == 3'h3 |=> flow.skip == ^s_q.acc;
  endproperty
  a_parity: assert property (p_parity) else $error("odd parity skip wrong");

  property p_ssub;
    s_exec(alj_pkg::OP_RSSUB) |=> store.valid && s_q.acc ==
      (($past(s_q.acc) & ~$past(s_q.quo)) | ($past(exec_cmd.y) & $past(s_q.quo)));
  endproperty
  a_ssub: assert property (p_ssub) else $error("substitute wrong");

  property p_target;
    go |=> flow.done && (!flow.jump || flow.target == $past(exec_cmd.addr));
  endproperty
  a_target: assert property (p_target) else $error("jump target wrong");

  property p_intjmp;
    go && exec_cmd.op == alj_pkg::OP_JARI && exec_cmd.j == 3'h1
      |=> flow.jump && flow.lock_clr && int_enable;
  endproperty
  a_intjmp: assert property (p_intjmp) else $error("jump 1 failed");

  property p_halt;
    go && exec_cmd.op == alj_pkg::OP_JMAN && exec_cmd.j == 3'h4
      |=> flow.jump ##0 halted [*2];
  endproperty
  a_halt: assert property (p_halt) else $error("halt jump failed");

endmodule

`default_nettype wire

// file: verif/alj_far_model.sv
`timescale 1ns/1ns
`default_nettype none

module alj_far_model (
  input wire logic clock,
  input wire alj_pkg::alj_store_t store,
  output logic [3:1] jump_sw,
  output logic [7:5] stop_sw,
  output logic [alj_pkg::NCH-1:0] inbuf_active
);
  logic [alj_pkg::W-1:0] mem [0:(1<<alj_pkg::AW)-1];

  initial begin
    jump_sw = 3'h0;
    stop_sw = 3'h0;
    inbuf_active = 16'h0000;
  end

  // panel and channel levels move only between instructions
  task automatic set_sw(input logic [2:0] js, input logic [2:0] ss, input logic [15:0] ib);
    @(posedge clock);
    jump_sw <= js;
    stop_sw <= ss;
    inbuf_active <= ib;
  endtask

  // storage takes the word at the edge where the store pulse stands
  always_ff @(posedge clock) begin
    if (store.valid) begin
      mem[store.addr] <= store.data;
    end
  end
endmodule

`default_nettype wire

// file: verif/arith_logic_jump_ops_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module arith_logic_jump_ops_tb_top;
  typedef logic [alj_pkg::W-1:0] alj_word_t;
  localparam alj_word_t A0 = 30'h3FFFFFF0;
  localparam alj_word_t Q0 = 30'h0000F0F5;
  localparam alj_word_t Y0 = 30'h0F0FF00F;
  localparam alj_word_t P0 = Y0 & Q0;
  logic clock, rst, exec_valid, exec_ready, halted, int_enable, reg_wr, reg_rd;
  alj_pkg::alj_cmd_t exec_cmd;
  alj_pkg::alj_store_t store;
  alj_pkg::alj_flow_t flow;
  logic [3:1] jump_sw;
  logic [7:5] stop_sw;
  logic [alj_pkg::NCH-1:0] inbuf_active;
  logic [1:0] reg_addr;
  alj_word_t reg_wdata, reg_rdata, rd;
  int mismatches, n_tests;

  alj_exec dut_u (.clock(clock), .rst(rst), .exec_valid(exec_valid), .exec_cmd(exec_cmd),
    .exec_ready(exec_ready), .store(store), .flow(flow), .halted(halted),
    .int_enable(int_enable), .jump_sw(jump_sw), .stop_sw(stop_sw),
    .inbuf_active(inbuf_active), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  alj_far_model far_u (.clock(clock), .store(store), .jump_sw(jump_sw), .stop_sw(stop_sw),
    .inbuf_active(inbuf_active));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input alj_word_t seen, input alj_word_t exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // end-around carry, so minus zero can come out of a sum
  function automatic alj_word_t oc_add(input alj_word_t a, input alj_word_t b);
    logic [30:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[29:0] + {29'h0, s[30]};
  endfunction

  task automatic wr(input logic [1:0] a, input alj_word_t v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rdr(input logic [1:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    rd = reg_rdata;
  endtask

  // operand address tracks the opcode so every store lands apart
  task automatic ex(input alj_pkg::alj_op_t op, input logic [2:0] j, input logic [3:0] ch,
                    input alj_word_t y);
    @(posedge clock);
    exec_valid <= 1'b1;
    exec_cmd <= '{op: op, j: j, k: 3'h3, chan: ch, addr: {9'h000, op}, y: y};
    @(posedge clock);
    exec_valid <= 1'b0;
    @(negedge clock);
  endtask

  task automatic d(input alj_pkg::alj_op_t op, input alj_word_t ea, input logic st,
                   input alj_word_t es);
    wr(alj_pkg::REG_ACC, A0);
    wr(alj_pkg::REG_QUO, Q0);
    ex(op, 3'h0, 4'h0, Y0);
    chk(flow.done, 1'b1);
    chk(flow.skip, 1'b0);
    chk(store.valid, st);
    if (st) begin
      chk(store.k, 3'h3);
      chk(store.data, es);
      chk(store.kdir, op == alj_pkg::OP_STSUM || op == alj_pkg::OP_STDIF ||
          op == alj_pkg::OP_LPST);
    end
    rdr(alj_pkg::REG_ACC);
    chk(rd, ea);
    rdr(alj_pkg::REG_QUO);
    chk(rd, Q0);
    if (st) begin
      chk(far_u.mem[{9'h000, op}], es);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(exec_ready, 1'b1);
    chk(halted, 1'b0);
    chk(int_enable, 1'b0);
    rdr(alj_pkg::REG_ACC);
    chk(rd, alj_pkg::ACC_RST);
    $display("test reset done");
  endtask

  task automatic t_data;
    d(alj_pkg::OP_STSUM, oc_add(A0, Q0), 1'b1, oc_add(A0, Q0));
    d(alj_pkg::OP_STDIF, oc_add(A0, ~Q0), 1'b1, oc_add(A0, ~Q0));
    d(alj_pkg::OP_RPQADD, oc_add(Q0, Y0), 1'b1, oc_add(Q0, Y0));
    d(alj_pkg::OP_RPQSUB, ~oc_add(Q0, ~Y0), 1'b1, ~oc_add(Q0, ~Y0));
    d(alj_pkg::OP_RPINC, oc_add(alj_pkg::ONE, Y0), 1'b1, oc_add(alj_pkg::ONE, Y0));
    d(alj_pkg::OP_RPDEC, ~oc_add(alj_pkg::ONE, ~Y0), 1'b1,
      ~oc_add(alj_pkg::ONE, ~Y0));
    d(alj_pkg::OP_LPENT, Y0 & A0, 1'b0, 30'h0);
    d(alj_pkg::OP_LPADD, oc_add(A0, P0), 1'b0, 30'h0);
    d(alj_pkg::OP_LPSUB, oc_add(A0, ~P0), 1'b0, 30'h0);
    d(alj_pkg::OP_MCMP, A0, 1'b0, 30'h0);
    d(alj_pkg::OP_LPREP, P0, 1'b1, P0);
    d(alj_pkg::OP_RLPADD, oc_add(A0, P0), 1'b1, oc_add(A0, P0));
    d(alj_pkg::OP_RLPSUB, oc_add(A0, ~P0), 1'b1, oc_add(A0, ~P0));
    d(alj_pkg::OP_LPST, A0, 1'b1, A0 & Q0);
    d(alj_pkg::OP_SSET, A0 | Y0, 1'b0, 30'h0);
    d(alj_pkg::OP_SCPL, A0 ^ Y0, 1'b0, 30'h0);
    d(alj_pkg::OP_SCLR, A0 & ~Y0, 1'b0, 30'h0);
    d(alj_pkg::OP_SSUB, (A0 & ~Q0) | P0, 1'b0, 30'h0);
    d(alj_pkg::OP_RSSET, A0 | Y0, 1'b1, A0 | Y0);
    d(alj_pkg::OP_RSCPL, A0 ^ Y0, 1'b1, A0 ^ Y0);
    d(alj_pkg::OP_RSCLR, A0 & ~Y0, 1'b1, A0 & ~Y0);
    d(alj_pkg::OP_RSSUB, (A0 & ~Q0) | P0, 1'b1, (A0 & ~Q0) | P0);
    $display("test data done");
  endtask

  task automatic t_skip;
    for (int j = 2; j < 4; j++) begin
      wr(alj_pkg::REG_ACC, A0);
      ex(alj_pkg::OP_LPENT, 3'(j), 4'h0, Y0);
      chk(flow.skip, (j == 2) ? ~^(Y0 & A0) : ^(Y0 & A0));
      ex(alj_pkg::OP_LPREP, 3'(j), 4'h0, 30'h00000007);
      chk(flow.skip, (j == 2) ? ~^(Q0 & 30'h7) : ^(Q0 & 30'h7));
    end
    ex(alj_pkg::OP_MCMP, 3'h1, 4'h0, Y0);
    chk(flow.skip, 1'b1);
    $display("test skip done");
  endtask

  // plus zero jumps on j=4, minus zero on j=5
  task automatic t_jari(input alj_word_t a, input alj_word_t q, input logic [7:0] m);
    wr(alj_pkg::REG_ACC, a);
    wr(alj_pkg::REG_QUO, q);
    for (int j = 0; j < 8; j++) begin
      ex(alj_pkg::OP_JARI, 3'(j), 4'h0, 30'h0);
      chk(flow.jump, m[j]);
      chk(flow.lock_clr, j < 2);
      if (m[j]) begin
        chk(flow.target, {9'h000, alj_pkg::OP_JARI});
      end
    end
    chk(int_enable, 1'b1);
    $display("test arithmetic jump done");
  endtask

  task automatic t_jman;
    far_u.set_sw(3'b010, 3'b010, 16'h0020);
    repeat (3) @(posedge clock);
    rdr(alj_pkg::REG_SW);
    chk(rd, 30'h12);
    for (int j = 0; j < 8; j++) begin
      ex(alj_pkg::OP_JMAN, 3'(j), 4'h0, 30'h0);
      chk(flow.jump, (8'hF5 >> j) & 8'h01);
      chk(halted, (8'h50 >> j) & 8'h01);
      if (halted === 1'b1) begin
        chk(exec_ready, 1'b0);
        ex(alj_pkg::OP_JMAN, 3'h0, 4'h0, 30'h0);
        chk(flow.done, 1'b0);
        wr(alj_pkg::REG_STAT, 30'h1);
        // the clear lands at the write edge; look once it has settled
        @(negedge clock);
        chk(halted, 1'b0);
      end
    end
    ex(alj_pkg::OP_JINB, 3'h0, 4'h5, 30'h0);
    chk(flow.jump, 1'b1);
    ex(alj_pkg::OP_JINB, 3'h0, 4'h4, 30'h0);
    chk(flow.jump, 1'b0);
    $display("test manual and buffer jump done");
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    exec_valid = 1'b0;
    exec_cmd = '0;
    reg_addr = 2'h0;
    reg_wdata = 30'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    mismatches = 0;
    n_tests = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    t_reset;
    t_data;
    t_skip;
    t_jari(30'h0, 30'h20000001, 8'h5A);
    t_jari(30'h3FFFFFFF, 30'h5, 8'hA6);
    t_jman;
    close_out;
  end

  // whole run is a few hundred cycles
  initial begin
    #100000;
    mismatches++;
    close_out;
  end
endmodule

`default_nettype wire
